// ---- verilog/eil_pkg.sv ----
/*
 * Constants for the external interrupt latch: register map, bit positions,
 * reset values and vector address.
 * Assumes a 32-bit APB register bus with word-aligned registers.
 */
package eil_pkg;

   // ==========================================================
   // Register map
   localparam logic [11:0] EIL_ADDR_STATUS_CONTROL = 12'h000;
   localparam logic [11:0] EIL_ADDR_BREAK_CONTROL = 12'h004;
   localparam logic [11:0] EIL_ADDR_PIN_LEVEL = 12'h008;
   localparam logic [11:0] EIL_ADDR_VECTOR = 12'h00c;

   // ==========================================================
   // Status/control, break control and pin level bit positions
   localparam int EIL_BIT_MODE = 0;
   localparam int EIL_BIT_MASK = 1;
   localparam int EIL_BIT_ACK = 2;
   localparam int EIL_BIT_PENDING = 3;
   localparam int EIL_BIT_BREAK_CLEAR_ENABLE = 0;
   localparam int EIL_BIT_PIN_HIGH = 0;
   localparam int EIL_BIT_PIN_LOW = 1;

   // ==========================================================
   // Reset values and vector
   localparam logic EIL_MODE_RESET = 1'b0;
   localparam logic EIL_MASK_RESET = 1'b0;
   localparam logic EIL_BREAK_CLEAR_ENABLE_RESET = 1'b0;
   localparam logic [15:0] EIL_VECTOR_HI_ADDR = 16'hfffa;
   localparam logic [15:0] EIL_VECTOR_LO_ADDR = 16'hfffb;

   typedef enum logic {EIL_EDGE_ONLY, EIL_EDGE_AND_LEVEL} eil_mode_t;

endpackage : eil_pkg

// ---- verilog/eil_external_interrupt_latch.sv ----
/*
 * External interrupt latch: one active-low pin sets a latch that requests
 * a CPU interrupt, with edge or edge-and-level sensitivity, a local mask,
 * a pending flag, software and vector-fetch acknowledge, break protection.
 * Assumes an APB master on clk, a CPU that pulses vector_fetch when it
 * fetches this vector and reports its global interrupt mask and break state.
 */
// Behaviour
// - A falling edge on the active-low pin sets the latch.
// - Fetching this interrupt's vector acknowledges and clears the latch.
// - Writing one to the acknowledge bit clears the latch.
// - Reset clears latch and sensitivity bit even with pin low.
// - Sensitivity bit one adds low level; zero is edge only, the reset default.
// - In edge-only mode an acknowledge clears the latch at once.
// - In level mode request ends after acknowledge and pin high, either order.
// - In level mode the request stays pending while the pin is low.
// - The request is forwarded only while the local mask is clear.
// - Mask bit is read/write, one disables, reset clears it.
// - Pending flag reads one while pending, independent of mask.
// - Acknowledge bit is write-only, reads zero, reset clears it.
// - A falling edge after an acknowledge sets the latch again.
// - The taken request vectors through the two fixed vector addresses.
// - With break clear enabled, acknowledges in break clear and stay cleared.
// - With break clear disabled, software acknowledges in break change nothing; a vector fetch still clears the latch.
// - The CPU global interrupt mask also blocks the request.
// - The pin level is visible for branch-if-high and branch-if-low.
`timescale 1ns/1ps
module eil_external_interrupt_latch
   import eil_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // External pin, active low
   input wire logic int_pin_b,
   // CPU side
   input wire logic vector_fetch,
   input wire logic cpu_global_mask,
   input wire logic break_state,
   output logic irq_request,
   output logic [15:0] vector_hi_addr,
   output logic [15:0] vector_lo_addr,
   output logic branch_if_pin_high,
   output logic branch_if_pin_low
);
   import eil_pkg::*;

   // ==========================================================
   // Reset release and pin synchroniser
   logic [1:0] rst_sync;
   logic rst_n;
   logic pin_meta;
   logic pin_sync;
   logic pin_prev;
   logic [2:0] pin_valid;

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         rst_sync <= 2'h0;
      else
         rst_sync <= {rst_sync[0], 1'b1};
   end
   assign rst_n = rst_sync[1];

   // Stages start at the pulled-up idle level of the pin
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pin_meta <= 1'b1;
         pin_sync <= 1'b1;
         pin_prev <= 1'b1;
      end
      else
      begin
         pin_meta <= int_pin_b;
         pin_sync <= pin_meta;
         pin_prev <= pin_sync;
      end
   end

   // Edges count only once real samples fill the chain, so a pin held
   // low through reset is no new event; an edge in the first cycles is lost
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         pin_valid <= 3'h0;
      else
         pin_valid <= {pin_valid[1:0], 1'b1};
   end

   // ==========================================================
   // Register bus decode
   logic wr_en;
   logic rd_en;
   logic mode;
   logic mask;
   logic break_clear_enable;
   logic latch;
   logic fall_edge;
   logic sw_ack;
   logic ack_allowed;
   logic any_ack;
   logic pending;

   function automatic logic hit(input logic [11:0] a, input logic [11:0] reg_addr);
      hit = (a == reg_addr);
   endfunction : hit

   assign wr_en = psel && penable && pwrite;
   assign rd_en = psel && penable && !pwrite;
   assign pready = 1'b1;
   assign pslverr = psel && penable &&
      !(hit(paddr, EIL_ADDR_STATUS_CONTROL) || hit(paddr, EIL_ADDR_BREAK_CONTROL) ||
        hit(paddr, EIL_ADDR_PIN_LEVEL) || hit(paddr, EIL_ADDR_VECTOR));

   // ==========================================================
   // Control bits
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         mode <= EIL_MODE_RESET;
         mask <= EIL_MASK_RESET;
         break_clear_enable <= EIL_BREAK_CLEAR_ENABLE_RESET;
      end
      else if (wr_en && hit(paddr, EIL_ADDR_STATUS_CONTROL))
      begin
         mode <= pwdata[EIL_BIT_MODE];
         mask <= pwdata[EIL_BIT_MASK];
      end
      else if (wr_en && hit(paddr, EIL_ADDR_BREAK_CONTROL))
         break_clear_enable <= pwdata[EIL_BIT_BREAK_CLEAR_ENABLE];
   end

   // ==========================================================
   // Interrupt latch
   assign fall_edge = pin_valid[2] && pin_prev && !pin_sync;
   assign sw_ack = wr_en && hit(paddr, EIL_ADDR_STATUS_CONTROL) && pwdata[EIL_BIT_ACK];
   // Break protects the flag from software acknowledge unless software opted in
   assign ack_allowed = !break_state || break_clear_enable;
   assign any_ack = vector_fetch || (sw_ack && ack_allowed);

   // A new edge wins over a same-cycle acknowledge so no event is lost
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         latch <= 1'b0;
      else if (fall_edge)
         latch <= 1'b1;
      else if (any_ack)
         latch <= 1'b0;
   end

   // Level mode: a low pin keeps the request alive after acknowledge
   assign pending = latch || (mode == EIL_EDGE_AND_LEVEL && !pin_sync);

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         irq_request <= 1'b0;
      else
         irq_request <= pending && !mask && !cpu_global_mask;
   end

   // ==========================================================
   // Read data and CPU-visible outputs
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         prdata <= 32'h0;
      else if (psel && !penable && !pwrite)
      begin
         prdata <= 32'h0;
         unique case (1'b1)
            hit(paddr, EIL_ADDR_STATUS_CONTROL):
            begin
               prdata[EIL_BIT_MODE] <= mode;
               prdata[EIL_BIT_MASK] <= mask;
               prdata[EIL_BIT_PENDING] <= pending;
            end
            hit(paddr, EIL_ADDR_BREAK_CONTROL):
               prdata[EIL_BIT_BREAK_CLEAR_ENABLE] <= break_clear_enable;
            hit(paddr, EIL_ADDR_PIN_LEVEL):
            begin
               prdata[EIL_BIT_PIN_HIGH] <= pin_sync;
               prdata[EIL_BIT_PIN_LOW] <= !pin_sync;
            end
            hit(paddr, EIL_ADDR_VECTOR):
               prdata <= {EIL_VECTOR_HI_ADDR, EIL_VECTOR_LO_ADDR};
            default:
               prdata <= 32'h0;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         branch_if_pin_high <= 1'b1;
         branch_if_pin_low <= 1'b0;
      end
      else
      begin
         branch_if_pin_high <= pin_sync;
         branch_if_pin_low <= !pin_sync;
      end
   end

   assign vector_hi_addr = EIL_VECTOR_HI_ADDR;
   assign vector_lo_addr = EIL_VECTOR_LO_ADDR;

   // ==========================================================
   // Checks
   sequence s_edge_seen;
      pin_valid[2] && pin_prev && !pin_sync;
   endsequence

   property p_edge_sets;
      @(posedge clk) disable iff (!rst_n) s_edge_seen |=> latch;
   endproperty
   a_edge_sets: assert property (p_edge_sets) else $error("edge did not set latch");

   property p_fetch_clears;
      @(posedge clk) disable iff (!rst_n) vector_fetch && !fall_edge |=> !latch;
   endproperty
   a_fetch_clears: assert property (p_fetch_clears) else $error("fetch left latch");

   property p_sw_ack_clears;
      @(posedge clk) disable iff (!rst_n)
         sw_ack && !break_state && !fall_edge |=> !latch;
   endproperty
   a_sw_ack_clears: assert property (p_sw_ack_clears) else $error("ack left latch");

   property p_edge_mode_clear;
      @(posedge clk) disable iff (!rst_n)
         mode == EIL_EDGE_ONLY && vector_fetch && !fall_edge |=> !pending;
   endproperty
   a_edge_mode_clear: assert property (p_edge_mode_clear) else $error("edge mode stuck");

   property p_level_holds;
      @(posedge clk) disable iff (!rst_n) mode && !pin_sync |-> pending;
   endproperty
   a_level_holds: assert property (p_level_holds) else $error("low pin not pending");

   property p_mask_gates;
      @(posedge clk) disable iff (!rst_n) $past(mask) || $past(cpu_global_mask) |-> !irq_request;
   endproperty
   a_mask_gates: assert property (p_mask_gates) else $error("masked request out");

   property p_request_follows;
      @(posedge clk) disable iff (!rst_n)
         pending && !mask && !cpu_global_mask |=> irq_request;
   endproperty
   a_request_follows: assert property (p_request_follows) else $error("request lost");

   property p_break_protects;
      @(posedge clk) disable iff (!rst_n)
         latch && sw_ack && break_state && !break_clear_enable && !vector_fetch |=> latch;
   endproperty
   a_break_protects: assert property (p_break_protects) else $error("break ack cleared");

   property p_pin_visible;
      @(posedge clk) disable iff (!rst_n) 1'b1 |=> branch_if_pin_high == $past(pin_sync);
   endproperty
   a_pin_visible: assert property (p_pin_visible) else $error("pin level wrong");

   property p_pin_low_visible;
      @(posedge clk) disable iff (!rst_n) 1'b1 |=> branch_if_pin_low == !$past(pin_sync);
   endproperty
   a_pin_low_visible: assert property (p_pin_low_visible) else $error("low level wrong");

   // Reset must win even with the pin held low
   sequence s_in_reset;
      !rst_n ##1 !rst_n;
   endsequence

   property p_reset_clears;
      @(posedge clk)
         s_in_reset |-> !latch && mode == EIL_EDGE_ONLY && !mask && !irq_request;
   endproperty
   a_reset_clears: assert property (p_reset_clears) else $error("reset left state");

   property p_edge_mode_sw_clear;
      @(posedge clk) disable iff (!rst_n)
         mode == EIL_EDGE_ONLY && sw_ack && ack_allowed && !pwdata[EIL_BIT_MODE] && !fall_edge
            |=> !pending;
   endproperty
   a_edge_mode_sw_clear: assert property (p_edge_mode_sw_clear) else $error("ack kept");

   sequence s_level_ack;
      mode == EIL_EDGE_AND_LEVEL && any_ack && !fall_edge;
   endsequence

   property p_level_ack;
      @(posedge clk) disable iff (!rst_n) s_level_ack |=> !latch;
   endproperty
   a_level_ack: assert property (p_level_ack) else $error("level ack kept latch");

   property p_level_release;
      @(posedge clk) disable iff (!rst_n)
         s_level_ack ##1 pin_sync |-> !pending;
   endproperty
   a_level_release: assert property (p_level_release) else $error("level not released");

   property p_break_clear;
      @(posedge clk) disable iff (!rst_n)
         sw_ack && break_state && break_clear_enable && !fall_edge |=> !latch;
   endproperty
   a_break_clear: assert property (p_break_clear) else $error("break ack ignored");

   // ==========================================================
   // Register checks
   sequence s_status_write;
      wr_en && hit(paddr, EIL_ADDR_STATUS_CONTROL);
   endsequence

   property p_mode_written;
      @(posedge clk) disable iff (!rst_n)
         s_status_write |=> mode == $past(pwdata[EIL_BIT_MODE]);
   endproperty
   a_mode_written: assert property (p_mode_written) else $error("mode not written");

   property p_mask_written;
      @(posedge clk) disable iff (!rst_n)
         s_status_write |=> mask == $past(pwdata[EIL_BIT_MASK]);
   endproperty
   a_mask_written: assert property (p_mask_written) else $error("mask not written");

   // Read data is latched in the setup cycle
   sequence s_status_read;
      psel && !penable && !pwrite && hit(paddr, EIL_ADDR_STATUS_CONTROL);
   endsequence

   property p_pending_read;
      @(posedge clk) disable iff (!rst_n)
         s_status_read |=> prdata[EIL_BIT_PENDING] == $past(pending) && !prdata[EIL_BIT_ACK];
   endproperty
   a_pending_read: assert property (p_pending_read) else $error("status read wrong");

endmodule : eil_external_interrupt_latch

// ---- verif/eil_irq_source.sv ----
/*
 * Model of the external source that drives the active-low interrupt pin.
 * Assumes the bench changes assert_low only just after a clock edge.
 */
`timescale 1ns/1ps
module eil_irq_source
(
   // Control from the bench
   input wire logic assert_low,
   // Pin
   output logic int_pin_b
);
   // ==========================================================
   // Pin drive
   // A released pin is pulled up, so it reads high
   assign int_pin_b = assert_low ? 1'b0 : 1'b1;
endmodule : eil_irq_source

// ---- verif/eil_external_interrupt_latch_tb.sv ----
/*
 * Self-checking bench for the external interrupt latch.
 * Assumes the zero-wait APB slave and the pin source model.
 */
`timescale 1ns/1ps
module eil_external_interrupt_latch_tb;
   import eil_pkg::*;
   // ==========================================================
   // Signals
   localparam logic [11:0] SC = EIL_ADDR_STATUS_CONTROL;
   localparam logic [11:0] BC = EIL_ADDR_BREAK_CONTROL;
   logic clk, rst_b, psel, penable, pwrite, pready, pslverr, err;
   logic pin_low, int_pin_b, vector_fetch, cpu_global_mask, break_state;
   logic irq_request, pin_hi, pin_lo;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [15:0] vec_hi, vec_lo;
   int num_errors = 0;
   int tests_run = 0;

   eil_external_interrupt_latch dut (.clk(clk), .rst_b(rst_b), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .int_pin_b(int_pin_b),
      .vector_fetch(vector_fetch), .cpu_global_mask(cpu_global_mask),
      .break_state(break_state), .irq_request(irq_request), .vector_hi_addr(vec_hi),
      .vector_lo_addr(vec_lo), .branch_if_pin_high(pin_hi), .branch_if_pin_low(pin_lo));
   eil_irq_source src (.assert_low(pin_low), .int_pin_b(int_pin_b));

   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   // ==========================================================
   // Shared tasks
   task automatic summarize;
      $display("tests_run %0d num_errors %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : summarize

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string s);
      tests_run++;
      if (got !== exp)
      begin
         num_errors++;
         $display("unexpected at %0t: %s got %h", $time, s, got);
      end
   endtask : chk

   task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (pready !== 1'b1 && n < 16);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1)
      begin
         num_errors++;
         summarize;
      end
   endtask : apb

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(a, 1'b1, d);
   endtask : wr

   task automatic rc(input logic [11:0] a, input logic [31:0] e, input string s);
      apb(a, 1'b0, 32'h0);
      chk(rd, e, s);
   endtask : rc

   task automatic pin(input logic v);
      @(posedge clk);
      pin_low <= v;
      repeat (6) @(posedge clk);
   endtask : pin

   task automatic wirq(input logic e);
      int n;
      n = 0;
      while (irq_request !== e && n < 12)
      begin
         @(posedge clk);
         n++;
      end
      chk({31'h0, irq_request}, {31'h0, e}, "irq");
      if (irq_request !== e)
         summarize;
   endtask : wirq

   // ==========================================================
   // Scenarios
   task automatic t_reset;
      rc(SC, 32'h0, "status");
      rc(BC, 32'h0, "break ctl");
      rc(EIL_ADDR_PIN_LEVEL, 32'h1, "pin level");
      rc(EIL_ADDR_VECTOR, 32'hfffafffb, "vector");
      chk({vec_hi, vec_lo}, 32'hfffafffb, "vector pins");
      rc(12'h010, 32'h0, "unmapped");
      chk({31'h0, err}, 32'h1, "slverr");
      $display("test reset done");
   endtask : t_reset

   task automatic t_edge;
      pin(1'b1);
      wirq(1'b1);
      chk({30'h0, pin_lo, pin_hi}, 32'h2, "branch pins");
      rc(EIL_ADDR_PIN_LEVEL, 32'h2, "pin level low");
      rc(SC, 32'h8, "pending");
      wr(SC, 32'h4);
      wirq(1'b0);
      rc(SC, 32'h0, "ack reads 0");
      pin(1'b0);
      pin(1'b1);
      wirq(1'b1);
      @(posedge clk);
      vector_fetch <= 1'b1;
      @(posedge clk);
      vector_fetch <= 1'b0;
      wirq(1'b0);
      pin(1'b0);
      $display("test edge done");
   endtask : t_edge

   task automatic t_mask;
      wr(SC, 32'h2);
      pin(1'b1);
      chk({31'h0, irq_request}, 32'h0, "masked irq");
      rc(SC, 32'ha, "masked pending");
      cpu_global_mask <= 1'b1;
      wr(SC, 32'h0);
      repeat (4) @(posedge clk);
      chk({31'h0, irq_request}, 32'h0, "global mask");
      cpu_global_mask <= 1'b0;
      wirq(1'b1);
      wr(SC, 32'h4);
      pin(1'b0);
      wirq(1'b0);
      $display("test mask done");
   endtask : t_mask

   task automatic t_level;
      wr(SC, 32'h1);
      pin(1'b1);
      wirq(1'b1);
      wr(SC, 32'h5);
      rc(SC, 32'h9, "held low");
      pin(1'b0);
      wirq(1'b0);
      pin(1'b1);
      pin(1'b0);
      rc(SC, 32'h9, "pin high first");
      wr(SC, 32'h7);
      rc(SC, 32'h3, "ack after high");
      wr(SC, 32'h0);
      $display("test level done");
   endtask : t_level

   task automatic t_break;
      break_state <= 1'b1;
      pin(1'b1);
      pin(1'b0);
      wr(SC, 32'h4);
      rc(SC, 32'h8, "protected");
      wr(BC, 32'h1);
      wr(SC, 32'h4);
      rc(SC, 32'h0, "break clear");
      break_state <= 1'b0;
      rc(SC, 32'h0, "after break");
      wr(BC, 32'h0);
      $display("test break done");
   endtask : t_break

   task automatic t_rerst;
      wr(SC, 32'h3);
      pin(1'b1);
      pin(1'b0);
      rc(SC, 32'hb, "before reset");
      pin(1'b1);
      rst_b <= 1'b0;
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      repeat (3) @(posedge clk);
      rc(SC, 32'h0, "after reset");
      repeat (4) @(posedge clk);
      chk({31'h0, irq_request}, 32'h0, "held low after reset");
      rc(SC, 32'h0, "still clear");
      pin(1'b0);
      $display("test rerst done");
   endtask : t_rerst

   initial
   begin
      rst_b = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      pin_low = 1'b0;
      vector_fetch = 1'b0;
      cpu_global_mask = 1'b0;
      break_state = 1'b0;
      repeat (6) @(posedge clk);
      rst_b <= 1'b1;
      repeat (3) @(posedge clk);
      t_reset;
      t_edge;
      t_mask;
      t_level;
      t_break;
      t_rerst;
      summarize;
   end
endmodule : eil_external_interrupt_latch_tb
